// >>> hw/spindle_pkg.sv
// Purpose: Shared constants for the spindle run and alarm interlock
// Assumes: 200 MHz core clock, AXI4-Lite register access with 32-bit data
// Notes:   Offsets are byte addresses of aligned 32-bit words
package spindle_pkg;
    localparam int unsigned CLK_HZ           = 200_000_000;
    localparam int unsigned CLK_KHZ          = CLK_HZ / 1000;
    localparam int unsigned STOP_HOLD_MS     = 40;
    localparam int unsigned STOP_HOLD_CYCLES = STOP_HOLD_MS * CLK_KHZ;

    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_SPEED  = 8'h04;
    localparam logic [7:0] ADDR_ACC0   = 8'h08;
    localparam logic [7:0] ADDR_ACC1   = 8'h0C;
    localparam logic [7:0] ADDR_ACC2   = 8'h10;
    localparam logic [7:0] ADDR_ACC3   = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;

    localparam int unsigned CTRL_SCALE_BIT = 0;
    localparam int unsigned CTRL_TQ_LSB    = 16;
    localparam int unsigned ST_ALARM_BIT   = 0;
    localparam int unsigned ST_PSM_BIT     = 1;
    localparam int unsigned ST_STOP_BIT    = 2;
    localparam int unsigned ST_EXCITE_BIT  = 3;
    localparam int unsigned ST_DIR_BIT     = 4;
    localparam int unsigned ST_CAUSE_LSB   = 8;
    localparam int unsigned ST_SPEED_LSB   = 16;

    localparam logic [14:0] ACC_RESET     = 15'd900;
    localparam logic [15:0] TQ_RESET      = 16'h0000;
    localparam logic [15:0] MAX_RPM       = 16'h2710;
    // Stop threshold is 0.75 % of maximum speed, in basis points
    localparam int unsigned STOP_BP       = 75;
    localparam int unsigned SCALE_FACTOR  = 10;
    localparam logic [1:0]  RESP_OKAY     = 2'b00;
    localparam logic [1:0]  RESP_SLVERR   = 2'b10;

    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_BRAKE, ST_ALARM} run_state_t;
endpackage

// >>> hw/spindle_ramp.sv
// Purpose: Speed ramp generator stepping one rpm at the programmed rate
// Assumes: rate_in in rpm per second, below CLK_HZ
// Notes:   zero_in drops the estimate to zero at once (coasting, no control)
`timescale 1ns/1ps
module spindle_ramp
    import spindle_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    input  wire logic        ce_in,
    input  wire logic        zero_in,
    input  wire logic [15:0] target_in,
    input  wire logic [18:0] rate_in,
    output logic      [15:0] speed_out
);
    logic [27:0] frac;
    logic [28:0] sum;

    assign sum = {1'b0, frac} + {10'h000, rate_in};

    // One rpm step each time the rate accumulator passes one second of clocks
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            frac      <= 28'h000_0000;
            speed_out <= 16'h0000;
        end else if (ce_in) begin
            if (zero_in || speed_out == target_in) begin
                frac <= 28'h000_0000;
                if (zero_in) begin
                    speed_out <= 16'h0000;
                end
            end else if (sum >= 29'(CLK_HZ)) begin
                frac <= 28'(sum - 29'(CLK_HZ));
                if (speed_out < target_in) begin
                    speed_out <= speed_out + 16'h0001;
                end else begin
                    speed_out <= speed_out - 16'h0001;
                end
            end else begin
                frac <= sum[27:0];
            end
        end
    end
endmodule

// >>> hw/spindle_run_alarm_interlock.sv
// Purpose: Run interlock, ramp select, torque limit and alarm latching
// Assumes: Command inputs arrive from a sequence controller, any phase
// Notes:   Behaviour
//
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module spindle_run_alarm_interlock
    import spindle_pkg::*;
#(
    parameter int unsigned    STOP_HOLD = STOP_HOLD_CYCLES,
    parameter logic [15:0]    MAX_SPEED = MAX_RPM,
    parameter int unsigned    CAUSES    = 8
)(
    input  wire logic              clk_in,
    input  wire logic              rst_in,
    input  wire logic              ce_in,
    input  wire logic              fwd_run_cmd_in,
    input  wire logic              rev_run_cmd_in,
    input  wire logic              estop_inactive_n_in,
    input  wire logic              machine_ready_in,
    input  wire logic              estop_contact_in,
    input  wire logic              gear_sel_hi_in,
    input  wire logic              gear_sel_lo_in,
    input  wire logic              torque_limit_cmd_in,
    input  wire logic              alarm_clear_in,
    input  wire logic [CAUSES-1:0] amp_fault_in,
    input  wire logic              power_supply_module_fault_in,
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic                   excite_out,
    output logic                   dir_ccw_out,
    output logic [15:0]            speed_out,
    output logic                   torque_limit_en_out,
    output logic [15:0]            torque_limit_out,
    output logic                   alarm_out,
    output logic                   stop_detected_out
);
    localparam int unsigned NSYNC = 9;
    localparam logic [15:0] STOP_THR = 16'((32'(MAX_SPEED) * STOP_BP) / 10000);

    run_state_t        st;
    logic [NSYNC-1:0]  sync1, sync2;
    logic              fwd_s, rev_s, estop_n_s, mrdy_s, contact_s;
    logic              gear_hi_s, gear_lo_s, torque_s, clr_s, clr_d;
    logic              clr_edge, run_ok, fwd_only, rev_only;
    logic [CAUSES-1:0] amp_alarm;
    logic              psm_alarm, alarm_now, unit_scale;
    logic [14:0]       acc [4];
    logic [1:0]        acc_sel;
    logic [18:0]       rate;
    logic [15:0]       speed_cmd, tq_limit, act_speed, target;
    logic [31:0]       hold_cnt;
    logic [7:0]        aw_addr;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              aw_held, w_held;

    // Two-flop synchronisers; first stage feeds nothing but the second
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sync1 <= '0;
            sync2 <= '0;
        end else if (ce_in) begin
            sync1 <= {fwd_run_cmd_in, rev_run_cmd_in, estop_inactive_n_in,
                      machine_ready_in, estop_contact_in, gear_sel_hi_in,
                      gear_sel_lo_in, torque_limit_cmd_in, alarm_clear_in};
            sync2 <= sync1;
        end
    end
    assign {fwd_s, rev_s, estop_n_s, mrdy_s, contact_s,
            gear_hi_s, gear_lo_s, torque_s, clr_s} = sync2;

    assign fwd_only = fwd_s && !rev_s;
    assign rev_only = rev_s && !fwd_s;
    assign run_ok   = estop_n_s && mrdy_s && contact_s;
    assign acc_sel  = {gear_hi_s, gear_lo_s};
    assign rate     = unit_scale ? 19'(acc[acc_sel] * SCALE_FACTOR)
                                 : {4'h0, acc[acc_sel]};
    assign alarm_now = (|amp_alarm) || psm_alarm;
    assign clr_edge  = clr_s && !clr_d;

    // Alarm latches: a new fault wins over a clear in the same cycle
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            amp_alarm <= '0;
            psm_alarm <= 1'b0;
            clr_d     <= 1'b0;
        end else if (ce_in) begin
            clr_d     <= clr_s;
            psm_alarm <= psm_alarm || power_supply_module_fault_in;
            if (clr_edge && alarm_now && amp_fault_in == '0) begin
                amp_alarm <= '0;
            end else begin
                amp_alarm <= amp_alarm | amp_fault_in;
            end
        end
    end

    // Run sequence; excitation and alarm output change on the same edge
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            st          <= ST_IDLE;
            excite_out  <= 1'b0;
            dir_ccw_out <= 1'b1;
            alarm_out   <= 1'b0;
            target      <= 16'h0000;
        end else if (ce_in) begin
            alarm_out <= alarm_now;
            case (st)
                ST_IDLE: begin
                    target <= 16'h0000;
                    if (alarm_now) begin
                        st <= ST_ALARM;
                    end else if (run_ok && (fwd_only || rev_only) && rate != 19'h0) begin
                        st          <= ST_RUN;
                        excite_out  <= 1'b1;
                        dir_ccw_out <= fwd_only;
                    end
                end
                ST_RUN: begin
                    if (alarm_now) begin
                        st         <= ST_ALARM;
                        excite_out <= 1'b0;
                    end else if (dir_ccw_out ? fwd_only : rev_only) begin
                        target <= speed_cmd;
                    end else begin
                        st     <= ST_BRAKE;
                        target <= 16'h0000;
                    end
                end
                ST_BRAKE: begin
                    target <= 16'h0000;
                    if (alarm_now) begin
                        st         <= ST_ALARM;
                        excite_out <= 1'b0;
                    end else if (act_speed == 16'h0000) begin
                        st         <= ST_IDLE;
                        excite_out <= 1'b0;
                    end
                end
                ST_ALARM: begin
                    excite_out <= 1'b0;
                    target     <= 16'h0000;
                    if (!alarm_now) begin
                        st <= ST_IDLE;
                    end
                end
                default: begin
                    st         <= ST_IDLE;
                    excite_out <= 1'b0;
                end
            endcase
        end
    end

    spindle_ramp u_ramp (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .ce_in     (ce_in),
        .zero_in   (alarm_now),
        .target_in (target),
        .rate_in   (rate),
        .speed_out (act_speed)
    );

    // Stop flag ignores run commands and is stretched to the minimum width
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            stop_detected_out <= 1'b1;
            hold_cnt          <= 32'h0000_0000;
            speed_out         <= 16'h0000;
            torque_limit_en_out <= 1'b0;
            torque_limit_out  <= 16'h0000;
        end else if (ce_in) begin
            speed_out           <= act_speed;
            torque_limit_en_out <= torque_s;
            torque_limit_out    <= torque_s ? tq_limit : 16'h0000;
            if (act_speed < STOP_THR) begin
                stop_detected_out <= 1'b1;
                if (!stop_detected_out) begin
                    hold_cnt <= 32'(STOP_HOLD);
                end else if (hold_cnt != 32'h0000_0000) begin
                    hold_cnt <= hold_cnt - 32'h0000_0001;
                end
            end else if (hold_cnt != 32'h0000_0000) begin
                hold_cnt <= hold_cnt - 32'h0000_0001;
            end else begin
                stop_detected_out <= 1'b0;
            end
        end
    end

    // AXI4-Lite write: address and data taken in either order
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            unit_scale    <= 1'b0;
            tq_limit      <= TQ_RESET;
            speed_cmd     <= 16'h0000;
            acc           <= '{default: ACC_RESET};
        end else if (ce_in) begin
            s_axi_awready <= !aw_held && !s_axi_bvalid && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !w_held && !s_axi_bvalid && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (aw_held && w_held && !s_axi_bvalid) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= RESP_OKAY;
                case (aw_addr)
                    ADDR_CTRL: begin
                        if (w_strb[0]) unit_scale <= w_data[CTRL_SCALE_BIT];
                        if (w_strb[2]) tq_limit[7:0]  <= w_data[CTRL_TQ_LSB +: 8];
                        if (w_strb[3]) tq_limit[15:8] <= w_data[CTRL_TQ_LSB + 8 +: 8];
                    end
                    ADDR_SPEED: begin
                        if (w_strb[0]) speed_cmd[7:0]  <= w_data[7:0];
                        if (w_strb[1]) speed_cmd[15:8] <= w_data[15:8];
                    end
                    ADDR_ACC0, ADDR_ACC1, ADDR_ACC2, ADDR_ACC3: begin
                        if (w_strb[0]) acc[aw_addr[3:2] - 2'd2][7:0]  <= w_data[7:0];
                        if (w_strb[1]) acc[aw_addr[3:2] - 2'd2][14:8] <= w_data[14:8];
                    end
                    ADDR_STATUS: begin
                    end
                    default: s_axi_bresp <= RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // AXI4-Lite read: one outstanding read, data registered with rvalid
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (ce_in) begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= RESP_OKAY;
                s_axi_rdata  <= 32'h0000_0000;
                case (s_axi_araddr)
                    ADDR_CTRL:  s_axi_rdata <= {tq_limit, 15'h0000, unit_scale};
                    ADDR_SPEED: s_axi_rdata <= {16'h0000, speed_cmd};
                    ADDR_ACC0:  s_axi_rdata <= {17'h0_0000, acc[0]};
                    ADDR_ACC1:  s_axi_rdata <= {17'h0_0000, acc[1]};
                    ADDR_ACC2:  s_axi_rdata <= {17'h0_0000, acc[2]};
                    ADDR_ACC3:  s_axi_rdata <= {17'h0_0000, acc[3]};
                    ADDR_STATUS: begin
                        s_axi_rdata[ST_ALARM_BIT]  <= alarm_out;
                        s_axi_rdata[ST_PSM_BIT]    <= psm_alarm;
                        s_axi_rdata[ST_STOP_BIT]   <= stop_detected_out;
                        s_axi_rdata[ST_EXCITE_BIT] <= excite_out;
                        s_axi_rdata[ST_DIR_BIT]    <= dir_ccw_out;
                        s_axi_rdata[ST_CAUSE_LSB +: 8]  <= 8'(amp_alarm);
                        s_axi_rdata[ST_SPEED_LSB +: 16] <= act_speed;
                    end
                    default: s_axi_rresp <= RESP_SLVERR;
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    sequence stop_rise_s;
        ce_in && $rose(stop_detected_out);
    endsequence
    sequence idle_blocked_s;
        ce_in && st == ST_IDLE && !(run_ok && (fwd_only || rev_only) && rate != 19'h0);
    endsequence

    alarm_coasts_a: assert property (@(posedge clk_in) disable iff (rst_in)
        alarm_out |-> !excite_out) else $error("excitation on during alarm");
    alarm_cuts_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (ce_in && alarm_now) |=> alarm_out && !excite_out) else $error("alarm not raised");
    start_gate_a: assert property (@(posedge clk_in) disable iff (rst_in)
        idle_blocked_s |=> st != ST_RUN && !excite_out) else $error("illegal start");
    both_cmds_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (ce_in && st == ST_IDLE && fwd_s && rev_s) |=> st != ST_RUN) else $error("both runs");
    stop_hold_a: assert property (@(posedge clk_in) disable iff (rst_in)
        stop_rise_s |-> stop_detected_out [*8]) else $error("stop flag too short");
    psm_sticky_a: assert property (@(posedge clk_in) disable iff (rst_in)
        psm_alarm |=> psm_alarm && alarm_out) else $error("supply alarm cleared");
    brake_off_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (ce_in && st == ST_BRAKE && act_speed == 16'h0000 && !alarm_now)
        |=> st == ST_IDLE && !excite_out) else $error("no power off after stop");
    torque_lim_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (ce_in && $stable(tq_limit)) |=> torque_limit_en_out == $past(torque_s)
        && (torque_limit_out == ($past(torque_s) ? $past(tq_limit) : 16'h0000)))
        else $error("torque limit wrong");
    clear_ok_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (ce_in && st == ST_ALARM && clr_edge && amp_fault_in == '0 && !psm_alarm
         && !power_supply_module_fault_in) |=> ##1 (!ce_in || st == ST_IDLE) [*1])
        else $error("alarm not released");
endmodule

// >>> tb/seq_ctrl_model.sv
// Purpose: Sequence controller model driving the spindle commands
// Assumes: Bench requests are levels {torque, reverse, forward}
// Notes:   On alarm every command drops and emergency stop is asserted
`timescale 1ns/1ps
module seq_ctrl_model (
    input  wire logic       clk_in,
    input  wire logic       alarm_in,
    input  wire logic [2:0] req_in,
    output logic      [2:0] cmd_out = 3'h0,
    output logic            estop_n_out = 1'b0
);
    // Cleared on the next clock; req_in passes again once the alarm releases, so a held request restarts the motor
    always @(posedge clk_in) begin
        cmd_out     <= alarm_in ? 3'h0 : req_in;
        estop_n_out <= ~alarm_in;
    end
endmodule

// >>> tb/spindle_run_alarm_interlock_tb.sv
// Purpose: Self-checking bench for the spindle run and alarm interlock
// Assumes: short stop hold, reduced maximum speed so the stop flag can fall
// Notes:   Large ramp constants with unit scale keep ramps short
`timescale 1ns/1ps
module spindle_run_alarm_interlock_tb;
    import spindle_pkg::*;
    logic        clk_in = 1'b0, rst_in = 1'b1, rdy = 1'b1, cnt = 1'b1, clr = 1'b0, psf = 1'b0;
    logic        awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
    logic        ce = 1'b1;
    // Low maximum speed puts the stop threshold at 1 rpm, reachable in short ramps
    localparam logic [15:0] MAXS = 16'h00C8;
    logic [1:0]  gear = 2'h0, bresp, rresp;
    logic [2:0]  req = 3'h0, cmd;
    logic [7:0]  amp = 8'h00, addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic        awready, wready, bvalid, arready, rvalid, excite, ccw, tq_en, alarm, stopd, esn;
    logic [15:0] speed, tq_lim;
    int          miscompares = 0, compares = 0, seed = 5257;
    logic [14:0] accv [4] = '{15'h7FFF, 15'h0000, 15'h7FFF, 15'h7FFF};
    spindle_run_alarm_interlock #(.STOP_HOLD(16), .MAX_SPEED(MAXS)) uut (
        .clk_in(clk_in), .rst_in(rst_in),
        .ce_in(ce), .fwd_run_cmd_in(cmd[0]), .rev_run_cmd_in(cmd[1]), .estop_inactive_n_in(esn),
        .machine_ready_in(rdy), .estop_contact_in(cnt), .gear_sel_hi_in(gear[1]),
        .gear_sel_lo_in(gear[0]), .torque_limit_cmd_in(cmd[2]), .alarm_clear_in(clr),
        .amp_fault_in(amp), .power_supply_module_fault_in(psf), .s_axi_awaddr(addr),
        .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(addr), .s_axi_arvalid(arv), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .excite_out(excite), .dir_ccw_out(ccw), .speed_out(speed), .torque_limit_en_out(tq_en),
        .torque_limit_out(tq_lim), .alarm_out(alarm), .stop_detected_out(stopd));
    seq_ctrl_model ctrl (.clk_in(clk_in), .alarm_in(alarm), .req_in(req), .cmd_out(cmd),
        .estop_n_out(esn));
    always #2.5 clk_in = ~clk_in;
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        if (miscompares == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // One transfer at a time; each channel released at its own handshake
    task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] ed, input logic [1:0] er);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        {awv, wv, bready} <= {3{wr}};
        {arv, rready} <= {2{~wr}};
        forever begin
            @(posedge clk_in);
            if (wr ? bvalid : rvalid) break;
            if (awready) awv <= 1'b0;
            if (wready) wv <= 1'b0;
            if (arready) arv <= 1'b0;
        end
        {bready, rready} <= 2'h0;
        if (!wr) cmp(rdata, ed);
        cmp(wr ? bresp : rresp, er);
    endtask
    task automatic wait_for(input logic v, input int lim, input logic sel);
        for (int i = 0; i < lim && (sel ? alarm : excite) !== v; i++) @(posedge clk_in);
        cmp(sel ? alarm : excite, v);
    endtask
    task automatic pulse_clear();
        repeat (6) @(posedge clk_in);
        clr <= 1'b1;
        repeat (6) @(posedge clk_in);
        clr <= 1'b0;
        repeat (6) @(posedge clk_in);
    endtask
    function automatic logic run_exp(input logic [1:0] d, input logic [14:0] a, input logic r,
                                     input logic c);
        return d != 2'h2 && a != 15'h0000 && r && c;
    endfunction
    initial begin
        logic [1:0]  d, g;
        logic [15:0] tgt;
        logic        run;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        for (int i = 0; i < 4; i++) begin
            axi(1'b0, ADDR_ACC0 + 8'(4 * i), '0, {17'h0_0000, ACC_RESET}, RESP_OKAY);
            axi(1'b1, ADDR_ACC0 + 8'(4 * i), {17'h0_0000, accv[i]}, '0, RESP_OKAY);
        end
        axi(1'b0, 8'h1C, '0, '0, RESP_SLVERR);
        axi(1'b1, 8'h1C, '0, '0, RESP_SLVERR);
        axi(1'b1, ADDR_CTRL, 32'h0123_0001, '0, RESP_OKAY);
        cmp(stopd, 1'b1);
        for (int i = 0; i < 8; i++) begin
            g = (i < 4) ? 2'(i) : 2'($random(seed));
            d = 2'($unsigned($random(seed)) % 3);
            tgt = 16'($unsigned($random(seed)) % 3 + 1);
            rdy <= |3'($random(seed));
            cnt <= |3'($random(seed));
            axi(1'b1, ADDR_SPEED, {16'h0000, tgt}, '0, RESP_OKAY);
            gear <= g;
            req <= {i[0], d != 2'h0, d != 2'h1};
            // Model flop, two sync flops and the state change
            repeat (8) @(posedge clk_in);
            run = run_exp(d, accv[g], rdy, cnt);
            cmp(excite, run);
            if (run) begin
                cmp(ccw, d == 2'h0);
                for (int k = 0; k < 2500 && speed !== tgt; k++) @(posedge clk_in);
                cmp(speed, tgt);
                repeat (20) @(posedge clk_in);
                cmp(stopd, 32'(tgt) * 10000 < 32'(MAXS) * 75);
            end
            cmp({tq_en, tq_lim}, i[0] ? 17'h1_0123 : 17'h0_0000);
            req <= 3'h0;
            wait_for(1'b0, 2500, 1'b0);
            cmp(speed, 16'h0000);
            cmp(stopd, 1'b1);
        end
        gear <= 2'h0;
        {rdy, cnt} <= 2'h3;
        pulse_clear();
        cmp(alarm, 1'b0);
        req <= 3'h1;
        wait_for(1'b1, 20, 1'b0);
        amp <= 8'h04;
        wait_for(1'b1, 10, 1'b1);
        cmp(excite, 1'b0);
        pulse_clear();
        cmp(alarm, 1'b1);
        amp <= 8'h00;
        req <= 3'h0;
        pulse_clear();
        cmp(alarm, 1'b0);
        // A fault seen only while the clock enable is low must not latch
        ce <= 1'b0;
        amp <= 8'h01;
        repeat (6) @(posedge clk_in);
        amp <= 8'h00;
        repeat (2) @(posedge clk_in);
        ce <= 1'b1;
        repeat (4) @(posedge clk_in);
        cmp(alarm, 1'b0);
        psf <= 1'b1;
        wait_for(1'b1, 10, 1'b1);
        psf <= 1'b0;
        pulse_clear();
        cmp(alarm, 1'b1);
        axi(1'b0, ADDR_STATUS, '0, 32'h0000_0017, RESP_OKAY);
        rst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        cmp(alarm, 1'b0);
        report_and_stop();
    end
    initial begin
        repeat (90000) @(posedge clk_in);
        miscompares++;
        report_and_stop();
    end
endmodule
